// [pmdis_pkg.sv]
package pmdis_pkg;

  // ****************************************
  // Register map (register indices and their byte addresses)
  // ****************************************
  localparam logic [15:0] OFF_CTRL0_IDX = 16'h010C;
  localparam logic [15:0] OFF_CTRL1_IDX = 16'h010D;
  localparam logic [17:0] OFF_CTRL0_ADDR = 18'h0_0430;
  localparam logic [17:0] OFF_CTRL1_ADDR = 18'h0_0434;
  localparam logic [7:0] OFF_CTRL_RESET = 8'h00;
  localparam int NUM_PERIPH = 16;

  // ****************************************
  // Bit positions in periph_off_ctrl0
  // ****************************************
  localparam int BIT_NV_ACCESS = 0;
  localparam int BIT_CHECKSUM_UNIT = 1;
  localparam int BIT_MEM_SCANNER = 2;
  localparam int BIT_SYSCLK_NET = 3;
  localparam int BIT_CLOCK_TUNING = 4;
  localparam int BIT_PIN_CHANGE_IRQ = 5;
  localparam int BIT_REFCLK_OUT = 6;
  localparam int BIT_TIMER0 = 7;

  // ****************************************
  // Bit positions in periph_off_ctrl1 (plus 8 in the flat vector)
  // ****************************************
  localparam int BIT_TIMER1 = 8;
  localparam int BIT_TIMER3 = 9;
  localparam int BIT_TIMER2 = 10;
  localparam int BIT_TIMER4 = 11;
  localparam int BIT_TIMER6 = 12;
  localparam int BIT_CAPCOMP1 = 13;
  localparam int BIT_CAPCOMP2 = 14;
  localparam int BIT_PULSE_WIDTH1 = 15;

  // Width of one peripheral's output bundle
  localparam int PERIPH_OUT_W = 8;
  localparam logic [7:0] SFR_ZERO = 8'h00;

endpackage : pmdis_pkg

// [pmdis_gate.sv]
`timescale 1ns/1ps
// ****************************************
// Per-peripheral gate: reset, register masking, output forcing
// ****************************************
module pmdis_gate (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic off,
  // Peripheral side
  input wire logic [7:0] periph_out,
  input wire logic [7:0] periph_rdata,
  // Gated side
  output logic periph_rst_n,
  output logic [7:0] gated_out,
  output logic [7:0] gated_rdata,
  output logic sfr_write_ok
);

  typedef struct packed {
    logic rst_n;
    logic [7:0] outs;
  } pmdis_gate_state_t;

  pmdis_gate_state_t state_reg;
  pmdis_gate_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    // Reset is held for the whole off time; registered so the peripheral sees a clean level
    state_next.rst_n = ~off; // [R04] [R07]
    state_next.outs = off ? 8'h00 : periph_out; // [R06]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign periph_rst_n = state_reg.rst_n;
  assign gated_out = state_reg.outs;
  // Masking follows the bit combinationally so no stale read slips through
  assign gated_rdata = off ? pmdis_pkg::SFR_ZERO : periph_rdata; // [R05] [R13]
  assign sfr_write_ok = ~off; // [R05]

endmodule : pmdis_gate

// [pmdis_top.sv]
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
// Contract
// [R01] All disable bits clear after system reset
// [R02] Bits read/write; 1 disables, 0 enables
// [R03] Disabled peripheral enters lowest power state
// [R04] Disabled peripheral held in reset, no function
// [R05] Disabled registers: writes dropped, reads zero
// [R06] Disabled peripheral outputs forced inactive
// [R07] Re-enable resumes with power-on reset values
// [R08] Software waits two cycles after re-enable
// [R09] First control register at 0x010C, layout
// [R10] Memory-access bit blocks memory and control
// [R11] Clock-network bit gates full-rate clock only
// [R12] Second control register at 0x010D, layout
// [R13] Bits act the edge after write
module pmdis_top (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral register access (8-bit bus shared by the 16 peripherals)
  input wire logic [15:0] sfr_sel,
  input wire logic sfr_wr,
  input wire logic [127:0] periph_rdata,
  output logic [15:0] sfr_wr_en,
  output logic [7:0] sfr_rdata,
  // Peripheral resets, clock gates and outputs
  output logic [15:0] periph_rst_n,
  output logic [15:0] periph_clk_en,
  input wire logic [127:0] periph_out,
  output logic [127:0] gated_out,
  // Memory access and clock network
  input wire logic nv_rd_req,
  input wire logic nv_wr_req,
  input wire logic nv_ctrl_wr,
  output logic nv_rd_grant,
  output logic nv_wr_grant,
  output logic nv_ctrl_wr_en,
  output logic fosc_periph_en,
  output logic fosc4_periph_en
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [15:0] off;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic [15:0] clk_en;
    logic [15:0] wr_en;
    logic [7:0] sfr_rd;
    logic nv_rd;
    logic nv_wr;
    logic nv_ctrl;
    logic fosc_en;
  } pmdis_top_state_t;

  pmdis_top_state_t state_reg;
  pmdis_top_state_t state_next;

  logic [127:0] gated_rdata_w;
  logic [15:0] write_ok_w;

  function automatic logic [1:0] pmdis_decode(input logic [17:0] addr);
    pmdis_decode = {addr == pmdis_pkg::OFF_CTRL1_ADDR, addr == pmdis_pkg::OFF_CTRL0_ADDR};
  endfunction : pmdis_decode

  // ****************************************
  // Per-peripheral gating
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < pmdis_pkg::NUM_PERIPH; gi++)
    begin : g_periph
      pmdis_gate u_gate (
        .pclk(pclk),
        .presetn(presetn),
        .off(state_reg.off[gi]),
        .periph_out(periph_out[gi*8 +: 8]),
        .periph_rdata(periph_rdata[gi*8 +: 8]),
        .periph_rst_n(periph_rst_n[gi]),
        .gated_out(gated_out[gi*8 +: 8]),
        .gated_rdata(gated_rdata_w[gi*8 +: 8]),
        .sfr_write_ok(write_ok_w[gi])
      );
    end
  endgenerate

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic [1:0] hit;
    logic access;
    logic [7:0] rd;
    hit = pmdis_decode(paddr);
    access = psel & penable & ~state_reg.ready;
    rd = 8'h00;
    state_next = state_reg;
    state_next.ready = access;
    state_next.slverr = access & ~(|hit);
    state_next.rdata = 32'h0000_0000;
    if (access && pwrite)
    begin
      // Writes land at the end of the access; the bits act from the next edge
      if (hit[0])
      begin
        state_next.off[7:0] = pwdata[7:0]; // [R02] [R09] [R13]
      end
      if (hit[1])
      begin
        state_next.off[15:8] = pwdata[7:0]; // [R02] [R12] [R13]
      end
    end
    if (access && !pwrite)
    begin
      if (hit[0])
      begin
        state_next.rdata = {24'h00_0000, state_reg.off[7:0]}; // [R02]
      end
      if (hit[1])
      begin
        state_next.rdata = {24'h00_0000, state_reg.off[15:8]}; // [R02]
      end
    end
    // Clock stopped on a disabled peripheral is the lowest power condition
    state_next.clk_en = ~state_next.off; // [R03]
    state_next.wr_en = sfr_sel & write_ok_w & {16{sfr_wr}}; // [R05]
    for (int i = 0; i < pmdis_pkg::NUM_PERIPH; i++)
    begin
      if (sfr_sel[i])
      begin
        rd = rd | gated_rdata_w[i*8 +: 8]; // [R05]
      end
    end
    state_next.sfr_rd = rd;
    // Software is expected to leave a freshly enabled peripheral alone briefly;
    // the gate already holds its reset release a cycle, so no extra guard is kept
    state_next.nv_rd = nv_rd_req & ~state_reg.off[pmdis_pkg::BIT_NV_ACCESS]; // [R10]
    state_next.nv_wr = nv_wr_req & ~state_reg.off[pmdis_pkg::BIT_NV_ACCESS]; // [R10]
    state_next.nv_ctrl = nv_ctrl_wr & ~state_reg.off[pmdis_pkg::BIT_NV_ACCESS]; // [R10]
    state_next.fosc_en = ~state_next.off[pmdis_pkg::BIT_SYSCLK_NET]; // [R11]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= '0;
      state_reg.off <= {pmdis_pkg::OFF_CTRL_RESET, pmdis_pkg::OFF_CTRL_RESET}; // [R01]
      state_reg.clk_en <= 16'hFFFF;
      state_reg.fosc_en <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = state_reg.rdata;
  assign pready = state_reg.ready;
  assign pslverr = state_reg.slverr;
  assign periph_clk_en = state_reg.clk_en;
  assign sfr_wr_en = state_reg.wr_en;
  assign sfr_rdata = state_reg.sfr_rd;
  assign nv_rd_grant = state_reg.nv_rd;
  assign nv_wr_grant = state_reg.nv_wr;
  assign nv_ctrl_wr_en = state_reg.nv_ctrl;
  assign fosc_periph_en = state_reg.fosc_en;
  // Quarter-rate clock is never touched by this block
  assign fosc4_periph_en = 1'b1; // [R11]

endmodule : pmdis_top

// [pmdis_top_sva.sv]
`timescale 1ns/1ps
// ****************************************
// Disable control checker
// ****************************************
module pmdis_top_sva (
  // Bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [17:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Peripheral side
  input wire logic [15:0] sfr_sel,
  input wire logic sfr_wr,
  input wire logic [15:0] sfr_wr_en,
  input wire logic [15:0] periph_rst_n,
  input wire logic [15:0] periph_clk_en,
  input wire logic [127:0] periph_out,
  input wire logic [127:0] gated_out,
  // Memory and clock
  input wire logic nv_rd_req,
  input wire logic nv_wr_req,
  input wire logic nv_ctrl_wr,
  input wire logic nv_rd_grant,
  input wire logic nv_wr_grant,
  input wire logic nv_ctrl_wr_en,
  input wire logic fosc_periph_en,
  input wire logic fosc4_periph_en
);
  logic [127:0] en_mask;
  always_comb
    for (int i = 0; i < 16; i++)
      en_mask[8*i+:8] = {8{periph_clk_en[i]}};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_reset_clear: assert property (!$past(presetn) |-> &periph_clk_en) else $error("not clear");
  a_rst_follows: assert property ($past(presetn) |-> periph_rst_n == $past(periph_clk_en)) else $error("rst");
  a_out_forced: assert property ($past(presetn) |-> gated_out == ($past(periph_out) & $past(en_mask)))
    else $error("out");
  a_wr_masked: assert property ($past(presetn) |-> sfr_wr_en == $past(sfr_sel & {16{sfr_wr}} & periph_clk_en))
    else $error("wr_en");
  a_nv_blocked: assert property ($past(presetn) |-> {nv_rd_grant, nv_wr_grant, nv_ctrl_wr_en} ==
    ($past({nv_rd_req, nv_wr_req, nv_ctrl_wr}) & {3{$past(periph_clk_en[0])}})) else $error("nv");
  a_clk_net: assert property (fosc_periph_en == periph_clk_en[3] && fosc4_periph_en) else $error("fosc");
  a_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready");
  a_err_unmapped: assert property (pready |-> pslverr ==
    !(paddr == pmdis_pkg::OFF_CTRL0_ADDR || paddr == pmdis_pkg::OFF_CTRL1_ADDR)) else $error("slverr");
endmodule : pmdis_top_sva
bind pmdis_top pmdis_top_sva chk_u (.*);

// [peripheral_module_disable_tb.sv]
`timescale 1ns/1ps
module peripheral_module_disable_tb;
  // ****************************************
  // Bench
  // ****************************************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic sfr_wr, nv_rd_req, nv_wr_req, nv_ctrl_wr, nv_rd_grant, nv_wr_grant, nv_ctrl_wr_en;
  logic fosc_periph_en, fosc4_periph_en;
  logic [17:0] paddr, a;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] sfr_sel, sfr_wr_en, periph_rst_n, periph_clk_en, m;
  logic [7:0] sfr_rdata;
  logic [127:0] periph_rdata, periph_out, gated_out, x;
  int fails, n_checks, cyc;
  pmdis_top dut_u (.*);
  always #12.5 pclk = ~pclk;
  task automatic chk(input string n, input logic [127:0] g, input logic [127:0] e);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s exp %0h got %0h", n, e, g);
    end
  endtask : chk
  // Idle cycle after each transfer keeps psel from being driven twice in one step
  task automatic apb(input logic w, input logic [17:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      finish_test();
    end
  end
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, sfr_wr, nv_rd_req, nv_wr_req, nv_ctrl_wr} = '0;
    paddr = '0;
    pwdata = '0;
    sfr_sel = '1;
    periph_rdata = {16{8'hA5}};
    periph_out = '1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    {sfr_wr, nv_rd_req, nv_wr_req, nv_ctrl_wr} <= 4'hF;
    @(posedge pclk);
    apb(1'b0, pmdis_pkg::OFF_CTRL0_ADDR, '0);
    chk("ctrl0", rd, '0);
    apb(1'b0, pmdis_pkg::OFF_CTRL1_ADDR, '0);
    chk("ctrl1", rd, '0);
    chk("rst_n", periph_rst_n, 16'hFFFF);
    apb(1'b0, 18'h0_0438, '0);
    chk("unmapped", {err, rd}, 33'h1_0000_0000);
    for (int i = 0; i < 16; i++)
    begin
      m = ~(16'h0001 << i);
      x = '1;
      x[8*i+:8] = 8'h00;
      a = i < 8 ? pmdis_pkg::OFF_CTRL0_ADDR : pmdis_pkg::OFF_CTRL1_ADDR;
      apb(1'b1, a, 32'hFFFF_FF00 | (1 << (i % 8)));
      apb(1'b0, a, '0);
      chk("readback", rd, 1 << (i % 8));
      chk("rst_n", periph_rst_n, m);
      chk("clk_en", periph_clk_en, m);
      chk("wr_en", sfr_wr_en, m);
      chk("outputs", gated_out, x);
      chk("nv", {nv_rd_grant, nv_wr_grant, nv_ctrl_wr_en}, i == 0 ? 3'h0 : 3'h7);
      chk("fosc", {fosc4_periph_en, fosc_periph_en}, i == 3 ? 2'h2 : 2'h3);
      sfr_sel <= ~m;
      repeat (2) @(posedge pclk);
      chk("rdata_off", sfr_rdata, 8'h00);
      apb(1'b1, a, '0);
      repeat (2) @(posedge pclk);
      chk("rst_back", periph_rst_n, 16'hFFFF);
      chk("rdata_on", sfr_rdata, 8'hA5);
      sfr_sel <= '1;
    end
    // A second system reset in mid-run must clear bits set before it
    apb(1'b1, pmdis_pkg::OFF_CTRL0_ADDR, 32'h0000_00FF);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, pmdis_pkg::OFF_CTRL0_ADDR, '0);
    chk("ctrl0_rst", rd, '0);
    chk("rst_n_rst", periph_rst_n, 16'hFFFF);
    finish_test();
  end
endmodule : peripheral_module_disable_tb
